// ===== logic/expander_target.sv
// Expander end: two targets (port registers and memory) behind one serial link
// Notes on behaviour
// - Master sends start then one address byte
// - Default addresses 0100_00A and 1010_00A
// - Each soft pin replaces next fixed bit
// - All six pins: first write byte picks target
// - Top bit zero: byte is port pointer
// - Top bit one: masked high memory address
// - Memory address is high byte then low
// - Read: write address, re-address, then read
// - Read advances counter, holds at last location
// - Access beyond end is not acknowledged
// - Write: address bytes then data bytes
// - Block writes best start page aligned
// - Page crossing stretches clock during programming
// - Port transfers start with pointer byte
// - Write protect input refuses memory writes
// - Memory disable refuses all memory access
`timescale 1ns/1ps
module expander_target #(
  parameter int MEM_BYTES = 27648,
  parameter int SOFT_PINS = 0,
  parameter int PROG_WAIT = dual_target_pkg::PROG_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  dual_target_if.device LINK,
  input wire logic FIXED_ADDR_PIN,
  input wire logic [5:0] SOFT_ADDR_PINS,
  input wire logic WRITE_PROTECT_INPUT,
  input wire logic MEM_DISABLE,
  output logic [7:0] PORT_PTR,
  output logic [7:0] PORT_WDATA,
  output logic PORT_WE,
  output logic PORT_RE,
  input wire logic [7:0] PORT_RDATA,
  output logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  output logic MEM_WE,
  input wire logic [7:0] MEM_RDATA,
  output logic PROG_BUSY
);
  initial begin
    if (SOFT_PINS < 0 || SOFT_PINS > dual_target_pkg::SOFT_PINS_MAX) $error("bad SOFT_PINS");
    if (MEM_BYTES < 1 || MEM_BYTES > 32768) $error("bad MEM_BYTES");
    if (PROG_WAIT < 1 || PROG_WAIT > 65535) $error("bad PROG_WAIT");
  end
  localparam logic [15:0] LAST = 16'(MEM_BYTES - 1);
  localparam logic [6:0] PIN_MASK = 7'((1 << (SOFT_PINS + 1)) - 1);
  localparam bit SHARED = (SOFT_PINS == dual_target_pkg::SOFT_PINS_MAX);
  // ------------------------------------------------------------
  // Line sampling and bus events
  // ------------------------------------------------------------
  logic scl_s, sda_s, scl_d, sda_d;
  bit_sync u_scl (.clk(CLK), .rstn(RSTN), .d(LINK.scl), .q(scl_s));
  bit_sync u_sda (.clk(CLK), .rstn(RSTN), .d(LINK.sda), .q(sda_s));
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_ev = scl_s && scl_d && sda_d && !sda_s;
  wire stop_ev = scl_s && scl_d && !sda_d && sda_s;
  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  wire [6:0] pin_addr = {SOFT_ADDR_PINS, FIXED_ADDR_PIN};
  wire [6:0] port_addr = (dual_target_pkg::PORT_BASE & ~PIN_MASK) | (pin_addr & PIN_MASK);
  wire [6:0] mem_addr_match = (dual_target_pkg::MEM_BASE & ~PIN_MASK) | (pin_addr & PIN_MASK);
  typedef enum {IDLE, ADDR, ACK, WDATA, RDATA, RACK, PROG, SKIP} phase_t;
  phase_t phase;
  logic [7:0] shreg;
  logic [3:0] bitcnt;
  logic rw;
  logic ack_drive;
  logic [1:0] wcount;
  logic mem_end;
  logic [15:0] prog_cnt;
  dual_target_pkg::target_t target;
  wire hit_port = (shreg[7:1] == port_addr);
  wire hit_mem = (shreg[7:1] == mem_addr_match) && !MEM_DISABLE;
  wire page_cross = (MEM_ADDR[dual_target_pkg::PAGE_BITS-1:0] == 6'h3f);
  wire mem_write_ok = !WRITE_PROTECT_INPUT && !MEM_DISABLE && !mem_end;
  wire at_last = (MEM_ADDR == LAST);
  // In shared mode a read goes to whichever target the last write chose
  wire addr_mem = SHARED ? (target == dual_target_pkg::SEL_MEM) : hit_mem;
  wire [15:0] low_load = {MEM_ADDR[15:8], shreg};
  wire low_ok = (low_load <= LAST);
  // Decision on the byte just received, taken on the falling edge after the eighth rising edge
  logic byte_ack;
  always_comb begin
    byte_ack = 1'b0;
    if (phase == ADDR) begin
      byte_ack = hit_port || hit_mem;
    end else if (target == dual_target_pkg::SEL_PORT) begin
      byte_ack = 1'b1;
    end else if (target == dual_target_pkg::SEL_MEM) begin
      if (wcount == 2'd0) byte_ack = !MEM_DISABLE;
      else if (wcount == 2'd1) byte_ack = !MEM_DISABLE && low_ok;
      else byte_ack = mem_write_ok;
    end else if (SHARED) begin
      byte_ack = !shreg[7] || !MEM_DISABLE;
    end
  end
  // ------------------------------------------------------------
  // Byte engine
  // ------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase <= IDLE;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      rw <= 1'b0;
      ack_drive <= 1'b0;
      wcount <= 2'd0;
      target <= dual_target_pkg::SEL_NONE;
      PORT_PTR <= dual_target_pkg::PTR_RESET;
      PORT_WDATA <= 8'h00;
      PORT_WE <= 1'b0;
      PORT_RE <= 1'b0;
      MEM_ADDR <= dual_target_pkg::MEM_ADDR_RESET;
      MEM_WDATA <= 8'h00;
      MEM_WE <= 1'b0;
      mem_end <= 1'b0;
      prog_cnt <= 16'h0000;
      PROG_BUSY <= 1'b0;
    end else begin
      PORT_WE <= 1'b0;
      PORT_RE <= 1'b0;
      MEM_WE <= 1'b0;
      // Counter steps once the write strobe has used the current address
      if (MEM_WE) begin
        if (at_last) mem_end <= 1'b1;
        else MEM_ADDR <= MEM_ADDR + 16'h0001;
      end
      if (start_ev) begin
        phase <= ADDR;
        bitcnt <= 4'h0;
        ack_drive <= 1'b0;
      end else if (stop_ev) begin
        phase <= IDLE;
        ack_drive <= 1'b0;
      end else begin
        case (phase)
          ADDR, WDATA: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
            end
            if (scl_fall && bitcnt == 4'h8) begin
              bitcnt <= 4'h0;
              ack_drive <= byte_ack;
              phase <= byte_ack ? ACK : SKIP;
              if (phase == ADDR && byte_ack) begin
                rw <= shreg[0];
                wcount <= 2'd0;
                if (SHARED && !shreg[0]) target <= dual_target_pkg::SEL_NONE;
                else target <= addr_mem ? dual_target_pkg::SEL_MEM : dual_target_pkg::SEL_PORT;
                if (shreg[0] && addr_mem && (mem_end || MEM_DISABLE)) begin
                  ack_drive <= 1'b0;
                  phase <= SKIP;
                end
              end else if (phase == WDATA && byte_ack) begin
                if (target == dual_target_pkg::SEL_NONE) begin
                  if (shreg[7]) begin
                    target <= dual_target_pkg::SEL_MEM;
                    MEM_ADDR[15:8] <= {1'b0, shreg[6:0]};
                    wcount <= 2'd1;
                  end else begin
                    target <= dual_target_pkg::SEL_PORT;
                    PORT_PTR <= shreg;
                    wcount <= 2'd1;
                  end
                end else if (target == dual_target_pkg::SEL_PORT) begin
                  if (wcount == 2'd0) PORT_PTR <= shreg;
                  else PORT_WE <= 1'b1;
                  PORT_WDATA <= shreg;
                  wcount <= 2'd1;
                end else if (wcount == 2'd0) begin
                  MEM_ADDR[15:8] <= {1'b0, shreg[6:0]};
                  wcount <= 2'd1;
                end else if (wcount == 2'd1) begin
                  MEM_ADDR[7:0] <= shreg;
                  mem_end <= 1'b0;
                  wcount <= 2'd2;
                end else begin
                  MEM_WDATA <= shreg;
                  MEM_WE <= 1'b1;
                  // Stretch starts as the clock of the acknowledge that follows this byte falls
                  if (page_cross || at_last) prog_cnt <= 16'(PROG_WAIT);
                end
              end
            end
          end
          ACK: begin
            if (scl_fall) begin
              ack_drive <= 1'b0;
              if (rw) begin
                phase <= RDATA;
                shreg <= (target == dual_target_pkg::SEL_MEM) ? MEM_RDATA : PORT_RDATA;
                if (target == dual_target_pkg::SEL_PORT) PORT_RE <= 1'b1;
                else if (at_last) mem_end <= 1'b1;
                else MEM_ADDR <= MEM_ADDR + 16'h0001;
              end else if (prog_cnt != 16'h0000) begin
                phase <= PROG;
                PROG_BUSY <= 1'b1;
              end else begin
                phase <= WDATA;
              end
            end
          end
          PROG: begin
            if (prog_cnt == 16'h0001) begin
              PROG_BUSY <= 1'b0;
              phase <= WDATA;
            end
            prog_cnt <= prog_cnt - 16'h0001;
          end
          RDATA: begin
            if (scl_fall) begin
              bitcnt <= bitcnt + 4'h1;
              if (bitcnt == 4'h7) begin
                phase <= RACK;
                bitcnt <= 4'h0;
              end else begin
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          RACK: begin
            if (scl_rise) begin
              if (sda_s || (target == dual_target_pkg::SEL_MEM && mem_end)) begin
                phase <= SKIP;
              end else begin
                phase <= ACK;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // Line drive
  // ------------------------------------------------------------
  assign LINK.sda_oe_d = ack_drive || (phase == RDATA && !shreg[7]);
  assign LINK.scl_oe_d = (phase == PROG);
endmodule // expander_target

// ===== logic/dual_target_pkg.sv
// Shared constants and types for the dual-target serial expander link
package dual_target_pkg;
  // ------------------------------------------------------------
  // Target address patterns
  // ------------------------------------------------------------
  localparam logic [6:0] PORT_BASE = 7'h20;
  localparam logic [6:0] MEM_BASE = 7'h50;
  localparam int SOFT_PINS_MAX = 6;
  // ------------------------------------------------------------
  // Timing, page size, reset values and target select type
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PROG_TIME_US = 5;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int HALF_BIT_CYCLES = 250;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_BITS = 6;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [15:0] MEM_ADDR_RESET = 16'h0000;
  localparam int MEM_TOP_BIT = 7;
  typedef enum logic [1:0] {SEL_NONE, SEL_PORT, SEL_MEM} target_t;
endpackage

// ===== logic/dual_target_if.sv
// Two-wire link between the master end and the expander end
`timescale 1ns/1ps
interface dual_target_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic scl_oe_d;
  logic sda_oe_d;
  wire scl = !((scl_oe_m && !scl_o_m) || scl_oe_d);
  wire sda = !((sda_oe_m && !sda_o_m) || sda_oe_d);
  modport master (output scl_o_m, scl_oe_m, sda_o_m, sda_oe_m, input scl, sda);
  modport device (output scl_oe_d, sda_oe_d, input scl, sda);
endinterface

// ===== logic/bit_sync.sv
// Two-stage synchroniser for the serial lines
`timescale 1ns/1ps
module bit_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // bit_sync

// ===== logic/link_master.sv
// Master end: issues byte transactions on the two-wire link
`timescale 1ns/1ps
module link_master #(
  parameter int HALF_BIT = dual_target_pkg::HALF_BIT_CYCLES
) (
  input wire logic CLK,
  input wire logic RSTN,
  dual_target_if.master LINK,
  input wire logic START_REQ,
  input wire logic STOP_REQ,
  input wire logic BYTE_REQ,
  input wire logic BYTE_READ,
  input wire logic [7:0] TX_BYTE,
  input wire logic SEND_NAK,
  output logic READY,
  output logic DONE,
  output logic [7:0] RX_BYTE,
  output logic ACKED
);
  initial begin
    if (HALF_BIT < 4 || HALF_BIT > 65536) $error("bad HALF_BIT");
  end
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;
  mstate_t st;
  logic [15:0] tick;
  logic [3:0] nbit;
  logic phase_hi;
  logic [8:0] sh;
  logic rd;
  logic scl_s, sda_s;
  bit_sync u_scl (.clk(CLK), .rstn(RSTN), .d(LINK.scl), .q(scl_s));
  bit_sync u_sda (.clk(CLK), .rstn(RSTN), .d(LINK.sda), .q(sda_s));
  wire tick_done = (tick == 16'(HALF_BIT - 1));
  // Held high clock counts only once the line really rose (stretching)
  wire tick_run = !(phase_hi && !scl_s);
  assign READY = (st == M_IDLE);
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= M_IDLE;
      tick <= 16'h0000;
      nbit <= 4'h0;
      phase_hi <= 1'b0;
      sh <= 9'h1ff;
      rd <= 1'b0;
      DONE <= 1'b0;
      RX_BYTE <= 8'h00;
      ACKED <= 1'b0;
      LINK.scl_o_m <= 1'b1;
      LINK.sda_o_m <= 1'b1;
      LINK.scl_oe_m <= 1'b0;
      LINK.sda_oe_m <= 1'b0;
    end else begin
      DONE <= 1'b0;
      if (tick_run) tick <= tick_done ? 16'h0000 : tick + 16'h0001;
      case (st)
        M_IDLE: begin
          tick <= 16'h0000;
          if (START_REQ) begin
            st <= M_START;
            LINK.sda_oe_m <= 1'b1;
            LINK.sda_o_m <= 1'b1;
            LINK.scl_oe_m <= 1'b1;
            LINK.scl_o_m <= 1'b1;
            phase_hi <= 1'b0;
          end else if (STOP_REQ) begin
            st <= M_STOP;
            LINK.sda_o_m <= 1'b0;
            phase_hi <= 1'b0;
          end else if (BYTE_REQ) begin
            st <= M_BIT;
            rd <= BYTE_READ;
            // Data changes only while the clock is low
            LINK.sda_o_m <= BYTE_READ ? 1'b1 : TX_BYTE[7];
            sh <= BYTE_READ ? {8'hff, SEND_NAK} : {TX_BYTE, 1'b1};
            nbit <= 4'h0;
            phase_hi <= 1'b0;
          end
        end
        M_START: begin
          if (tick_done) begin
            if (!phase_hi) begin
              LINK.sda_o_m <= 1'b0;
              phase_hi <= 1'b1;
            end else begin
              LINK.scl_o_m <= 1'b0;
              st <= M_IDLE;
              DONE <= 1'b1;
            end
          end
        end
        M_BIT: begin
          if (tick_done) begin
            if (!phase_hi) begin
              LINK.scl_o_m <= 1'b1;
              phase_hi <= 1'b1;
            end else begin
              LINK.scl_o_m <= 1'b0;
              phase_hi <= 1'b0;
              sh <= {sh[7:0], sda_s};
              LINK.sda_o_m <= sh[7];
              nbit <= nbit + 4'h1;
              if (nbit == 4'h8) begin
                st <= M_IDLE;
                DONE <= 1'b1;
                ACKED <= !sda_s;
                RX_BYTE <= sh[7:0];
                LINK.sda_o_m <= rd ? 1'b1 : 1'b0;
              end
            end
          end
        end
        default: begin
          if (tick_done) begin
            if (!phase_hi) begin
              LINK.scl_o_m <= 1'b1;
              phase_hi <= 1'b1;
            end else begin
              LINK.sda_o_m <= 1'b1;
              st <= M_IDLE;
              DONE <= 1'b1;
            end
          end
        end
      endcase
    end
  end
endmodule // link_master

// ===== verif/dual_target_props.sv
// Concurrent checks on the link wires and the memory side of the expander end
`timescale 1ns/1ps
module dual_target_props #(
  parameter int MEM_BYTES = 130,
  parameter int PROG_WAIT = 20
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic scl,
  input wire logic scl_oe_d,
  input wire logic PROG_BUSY,
  input wire logic MEM_WE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic WRITE_PROTECT_INPUT,
  input wire logic MEM_DISABLE
);
  localparam int PAGE_WIN = 400;
  logic [15:0] busy_cnt;
  logic [15:0] next_busy_cnt;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // ------------------------------------------------------------
  // Stretch length counter
  // ------------------------------------------------------------
  assign next_busy_cnt = PROG_BUSY ? busy_cnt + 16'h0001 : 16'h0000;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      busy_cnt <= 16'h0000;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  sequence page_end_write;
    MEM_WE && MEM_ADDR[5:0] == 6'h3f;
  endsequence
  sequence stretch_soon;
    ##[1:PAGE_WIN] PROG_BUSY;
  endsequence
  a_stretch_holds_scl: assert property (PROG_BUSY |-> scl_oe_d && !scl)
    else $error("clock not held low while programming");
  a_clock_only_stretch: assert property (scl_oe_d |-> PROG_BUSY)
    else $error("clock held low outside programming");
  a_stretch_bounded: assert property (busy_cnt <= 16'(PROG_WAIT + 16))
    else $error("clock stretch lasts too long");
  a_page_end_stretch: assert property (page_end_write |-> stretch_soon)
    else $error("no stretch after page end write");
  a_protect_no_write: assert property (WRITE_PROTECT_INPUT |-> !MEM_WE)
    else $error("memory written while protected");
  a_disable_no_write: assert property (MEM_DISABLE |-> !MEM_WE)
    else $error("memory written while disabled");
  a_addr_step_write: assert property (MEM_WE |=> MEM_ADDR == $past(MEM_ADDR) + 16'h0001 ||
    ($past(MEM_ADDR) == 16'(MEM_BYTES - 1) && $stable(MEM_ADDR)))
    else $error("address counter did not step after write");
  a_write_in_range: assert property (MEM_WE |-> MEM_ADDR < 16'(MEM_BYTES))
    else $error("write beyond last location");
  a_write_gap_min: assert property (MEM_WE |=> !MEM_WE [*8])
    else $error("memory writes too close together");
endmodule // dual_target_props

// ===== verif/i2c_dual_target_eeprom_access_tb_top.sv
// Bench joining the master end to the expander end in shared address mode
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module i2c_dual_target_eeprom_access_tb_top;
  localparam int HALF = 8;
  localparam int PW = 20;
  localparam int MEMB = 130;
  localparam logic [7:0] AW = 8'hae;
  localparam logic [7:0] AR = 8'haf;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic start_req = 1'b0;
  logic stop_req = 1'b0;
  logic byte_req = 1'b0;
  logic byte_read = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic send_nak = 1'b0;
  logic wp = 1'b0;
  logic mem_disable = 1'b0;
  logic ready, done, acked, port_we, port_re, mem_we, prog_busy, saw_busy;
  logic [7:0] rx_byte, port_ptr, port_wdata, port_rdata, mem_wdata, mem_rdata, wptr, wdat;
  logic [15:0] mem_addr;
  logic [7:0] mem [0:MEMB-1];
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_port_re = 0;
  dual_target_if link();
  link_master #(.HALF_BIT(HALF)) u_link_master (.CLK(clk), .RSTN(rstn), .LINK(link.master),
    .START_REQ(start_req), .STOP_REQ(stop_req), .BYTE_REQ(byte_req), .BYTE_READ(byte_read),
    .TX_BYTE(tx_byte), .SEND_NAK(send_nak), .READY(ready), .DONE(done), .RX_BYTE(rx_byte),
    .ACKED(acked));
  expander_target #(.MEM_BYTES(MEMB), .SOFT_PINS(6), .PROG_WAIT(PW)) u_expander_target (
    .CLK(clk), .RSTN(rstn), .LINK(link.device), .FIXED_ADDR_PIN(1'b1),
    .SOFT_ADDR_PINS(6'h2b), .WRITE_PROTECT_INPUT(wp), .MEM_DISABLE(mem_disable),
    .PORT_PTR(port_ptr), .PORT_WDATA(port_wdata), .PORT_WE(port_we), .PORT_RE(port_re),
    .PORT_RDATA(port_rdata), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_WE(mem_we),
    .MEM_RDATA(mem_rdata), .PROG_BUSY(prog_busy));
  dual_target_props #(.MEM_BYTES(MEMB), .PROG_WAIT(PW)) u_dual_target_props (.CLK(clk),
    .RSTN(rstn), .scl(link.scl), .scl_oe_d(link.scl_oe_d), .PROG_BUSY(prog_busy),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .WRITE_PROTECT_INPUT(wp),
    .MEM_DISABLE(mem_disable));
  // ------------------------------------------------------------
  // Clock, target-side models and run limit
  // ------------------------------------------------------------
  always #5 clk = ~clk;
  assign port_rdata = port_ptr ^ 8'hc3;
  assign mem_rdata = mem[mem_addr];
  always @(posedge clk) begin
    if (mem_we === 1'b1) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (port_we === 1'b1) begin
      wptr <= port_ptr;
      wdat <= port_wdata;
    end
    if (prog_busy === 1'b1) begin
      saw_busy <= 1'b1;
    end
    if (port_re === 1'b1) begin
      n_port_re++;
    end
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Link request tasks
  // ------------------------------------------------------------
  task automatic op(input logic [1:0] k, input logic rd, input logic [7:0] b, input logic nak);
    @(posedge clk);
    while (ready !== 1'b1) begin
      @(posedge clk);
    end
    start_req <= (k == 2'h0);
    stop_req <= (k == 2'h1);
    byte_req <= (k == 2'h2);
    byte_read <= rd;
    tx_byte <= b;
    send_nak <= nak;
    @(posedge clk);
    start_req <= 1'b0;
    stop_req <= 1'b0;
    byte_req <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge clk);
    end
  endtask
  task automatic start();
    op(2'h0, 1'b0, 8'h00, 1'b0);
  endtask
  task automatic stop();
    op(2'h1, 1'b0, 8'h00, 1'b0);
  endtask
  task automatic wr(input logic [7:0] b, input logic ack);
    op(2'h2, 1'b0, b, 1'b0);
    `CHK("ack", ack, acked)
  endtask
  task automatic rd(input logic nak, input logic [7:0] exp);
    op(2'h2, 1'b1, 8'h00, nak);
    `CHK("rx", exp, rx_byte)
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    saw_busy = 1'b0;
    for (int i = 0; i < MEMB; i++) begin
      mem[i] = 8'(i) ^ 8'h5a;
    end
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    start();
    wr(8'h40, 1'b0);
    stop();
    $display("test address done");
    start();
    wr(AW, 1'b1);
    wr(8'h12, 1'b1);
    wr(8'h9c, 1'b1);
    stop();
    `CHK("wptr", 8'h12, wptr)
    `CHK("wdat", 8'h9c, wdat)
    start();
    wr(AW, 1'b1);
    wr(8'h12, 1'b1);
    start();
    wr(AR, 1'b1);
    rd(1'b1, 8'hd1);
    `CHK("port_re", 1, n_port_re)
    stop();
    $display("test port done");
    start();
    wr(AW, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h3e, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr(8'hd0 + 8'(i), 1'b1);
    end
    stop();
    `CHK("addr", 16'h0041, mem_addr)
    `CHK("stretch", 1'b1, saw_busy)
    start();
    wr(AW, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h3e, 1'b1);
    start();
    wr(AR, 1'b1);
    rd(1'b0, 8'hd0);
    rd(1'b0, 8'hd1);
    rd(1'b1, 8'hd2);
    stop();
    $display("test memory done");
    start();
    wr(AW, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'he0, 1'b1);
    wr(8'he1, 1'b1);
    wr(8'he2, 1'b0);
    stop();
    `CHK("last", 16'h0081, mem_addr)
    `CHK("memend", 8'he1, mem[129])
    start();
    wr(AW, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h90, 1'b0);
    stop();
    $display("test end done");
    wp <= 1'b1;
    start();
    wr(AW, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h10, 1'b1);
    wr(8'h77, 1'b0);
    stop();
    wp <= 1'b0;
    `CHK("prot", 8'h4a, mem[16])
    mem_disable <= 1'b1;
    start();
    wr(AW, 1'b1);
    wr(8'h80, 1'b0);
    stop();
    mem_disable <= 1'b0;
    $display("test refuse done");
    final_report();
  end
endmodule // i2c_dual_target_eeprom_access_tb_top
